// ### src/ctbl_regs.vh
// register offsets, field positions and reset values of the trace and breakpoint block
`ifndef CTBL_REGS_VH
`define CTBL_REGS_VH

// byte offsets
`define CTBL_STAT_OFF    7'h00
`define CTBL_BASE_OFF    7'h04
`define CTBL_CTRL_OFF    7'h08
`define CTBL_DSR_OFF     7'h0C
`define CTBL_CHCTL_BASE  7'h20
`define CTBL_CAR_BASE    7'h40

// status word fields
`define CTBL_STAT_TE     0
`define CTBL_STAT_TP     1

// control word fields
`define CTBL_CTRL_GEN    0

// channel control fields
`define CTBL_CH_PC       0
`define CTBL_CH_MSK_LO   1
`define CTBL_CH_MSK_HI   2
`define CTBL_CH_RANGE    3
`define CTBL_CH_WR       4
`define CTBL_CH_RD       5
`define CTBL_CH_CPLX     6
`define CTBL_CH_W        7

// reset values
`define CTBL_CH_RST      7'h00
`define CTBL_BASE_RST    24'h000000

// exception codes at the pre-execution check
`define CTBL_EXC_RUN     3'h0
`define CTBL_EXC_BRK     3'h1
`define CTBL_EXC_ADR     3'h2
`define CTBL_EXC_IRQ     3'h3
`define CTBL_EXC_STEP    3'h4

// bus answer latency in cycles
`define CTBL_BUS_WAIT    1

`endif

// ### src/ctbl_core.v
// trace, breakpoint-instruction and address-compare debug logic of the core
// Functional notes
// - trace bits ignored when hardware debugger attached
// - trace enable bit turns on stepping
// - each instruction copies enable into pending
// - pending set raises trace trap before instruction
// - other exception handlers finish before trace
// - restored pending bit traps before re-execution
// - status loads and returns may alter pending
// - wait with tracing traps after interrupt returns
// - breakpoint instruction traps without debugger
// - breakpoint instruction enters debug mode with debugger
// - debug registers reached only by privileged moves
// - each register bank controls two channels
// - debugger present blocks core control/status access
// - masked fetch match ignores up to three bits
// - fetch range pairs two compare registers inclusively
// - data match on exact address, read/write
// - masked data match over up to 8 bytes
// - data range pairs two compare registers
// - complex match combines two channels
// - every fetch compared against all compare registers
// - fetch match tags instruction; debug before execution
// - check order debug, address, interrupt, trace
`include "ctbl_regs.vh"

module ctbl_core #(
  parameter AW     = 24,
  parameter NBANK  = 4
) (
  input  wire          sys_clk,
  input  wire          rst,
  // privileged register moves arrive as bus cycles
  input  wire [6:0]    avs_address,
  input  wire          avs_read,
  input  wire          avs_write,
  input  wire [31:0]   avs_writedata,
  output reg  [31:0]   avs_readdata,
  output wire          avs_waitrequest,
  // core side
  input  wire          hw_dbg_present,
  input  wire          fetch_valid,
  input  wire [AW-1:0] fetch_addr,
  output reg           fetch_tag_r,
  input  wire          data_valid,
  input  wire          data_write,
  input  wire [AW-1:0] data_addr,
  input  wire          inst_begin,
  input  wire          exec_tagged,
  input  wire          bad_addr_pending,
  input  wire          irq_pending,
  input  wire          inst_bpt,
  input  wire          exc_enter,
  input  wire          exc_return,
  input  wire          ret_trace_enable,
  input  wire          ret_trace_pending,
  output reg           exc_valid_r,
  output reg  [2:0]    exc_code_r,
  output reg           bpt_trap_r,
  output reg           dbg_mode_req_r,
  output wire          trace_enable_bit,
  output wire          trace_pending_bit
);

  localparam NCH = 2 * NBANK;

  reg              te_r;
  reg              tp_r;
  reg  [AW-1:0]    base_r;
  reg              gen_r;
  reg  [NCH-1:0]   hit_r;
  reg              dbg_pend_r;
  reg  [NCH-1:0]   seen_r;
  reg  [`CTBL_CH_W-1:0] ctl_r [0:NCH-1];
  reg  [AW-1:0]    car_r [0:NCH-1];
  reg              ack_r;
  reg  [31:0]      rd_nxt;

  wire [NCH-1:0]   fhit;
  wire [NCH-1:0]   dhit;
  wire             req;
  wire             wr_go;
  wire             rd_ok;
  wire             t_eff;
  wire             p_eff;
  wire             any_fhit;
  wire             any_dhit;
  wire             take_dbg;
  integer          k;
  integer          kw;
  integer          ka;
  integer          ks;

  assign trace_enable_bit  = te_r;
  assign trace_pending_bit = tp_r;

  assign t_eff = te_r & ~hw_dbg_present;
  assign p_eff = tp_r & ~hw_dbg_present;

  // one wait cycle, then answer; keeps timing fixed for the master
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_go           = avs_write & ack_r;

  // control and status hidden from the core while the debugger is present
  assign rd_ok = ~hw_dbg_present;

  always @(posedge sys_clk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always @* begin
    rd_nxt = 32'h00000000;
    case (avs_address)
      `CTBL_STAT_OFF: begin
        rd_nxt[`CTBL_STAT_TE] = te_r;
        rd_nxt[`CTBL_STAT_TP] = tp_r;
      end
      `CTBL_BASE_OFF: begin
        rd_nxt[AW-1:0] = base_r;
      end
      `CTBL_CTRL_OFF: begin
        rd_nxt[`CTBL_CTRL_GEN] = gen_r & rd_ok;
      end
      `CTBL_DSR_OFF: begin
        rd_nxt[NCH-1:0] = rd_ok ? hit_r : {NCH{1'b0}};
        rd_nxt[NCH]     = dbg_pend_r & rd_ok;
      end
      default: begin
        for (k = 0; k < NCH; k = k + 1) begin
          if (avs_address == `CTBL_CHCTL_BASE + 4 * k && rd_ok) begin
            rd_nxt[`CTBL_CH_W-1:0] = ctl_r[k];
          end
          if (avs_address == `CTBL_CAR_BASE + 4 * k) begin
            rd_nxt[AW-1:0] = car_r[k];
          end
        end
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_r) begin
      avs_readdata <= rd_nxt;
    end
  end

  // base register: stored for the monitor, no effect on matching
  always @(posedge sys_clk) begin
    if (rst) begin
      base_r <= `CTBL_BASE_RST;
    end else if (wr_go && avs_address == `CTBL_BASE_OFF) begin
      base_r <= avs_writedata[AW-1:0];
    end
  end

  // writes dropped while debugger owns them
  always @(posedge sys_clk) begin
    if (rst) begin
      gen_r <= 1'b0;
      for (kw = 0; kw < NCH; kw = kw + 1) begin
        ctl_r[kw] <= `CTBL_CH_RST;
      end
    end else if (wr_go && rd_ok) begin
      if (avs_address == `CTBL_CTRL_OFF) begin
        gen_r <= avs_writedata[`CTBL_CTRL_GEN];
      end
      for (kw = 0; kw < NCH; kw = kw + 1) begin
        if (avs_address == `CTBL_CHCTL_BASE + 4 * kw) begin
          ctl_r[kw] <= avs_writedata[`CTBL_CH_W-1:0];
        end
      end
    end
  end

  // compare addresses stay core-reachable in both cases
  always @(posedge sys_clk) begin
    if (rst) begin
      for (ka = 0; ka < NCH; ka = ka + 1) begin
        car_r[ka] <= {AW{1'b0}};
      end
    end else if (wr_go) begin
      for (ka = 0; ka < NCH; ka = ka + 1) begin
        if (avs_address == `CTBL_CAR_BASE + 4 * ka) begin
          car_r[ka] <= avs_writedata[AW-1:0];
        end
      end
    end
  end

  // two channels per bank, NBANK banks
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      wire [1:0]    msk;
      wire [AW-1:0] amask;
      wire          even;
      wire          rng;
      wire          cplx;
      wire          slave;
      wire          on;
      wire          f_in;
      wire          d_in;
      wire          f_m;
      wire          d_m;
      wire          d_cond;
      wire          d_kind;
      wire [AW-1:0] hi;

      assign even = (i % 2) == 0;
      assign msk  = ctl_r[i][`CTBL_CH_MSK_HI:`CTBL_CH_MSK_LO];
      assign rng  = even & ctl_r[i][`CTBL_CH_RANGE];
      assign cplx = even & ctl_r[i][`CTBL_CH_CPLX];
      // constant index keeps the last channel inside the array
      assign hi   = car_r[i | 1];
      // odd partner of a range or complex pair keeps quiet
      assign slave = ~even & (ctl_r[i - (i % 2)][`CTBL_CH_RANGE] |
                              ctl_r[i - (i % 2)][`CTBL_CH_CPLX]);
      assign on = gen_r & ~slave;
      assign amask = {AW{1'b1}} << msk;

      assign f_in = rng ? (fetch_addr >= car_r[i] && fetch_addr <= hi)
                        : (((fetch_addr ^ car_r[i]) & amask) == {AW{1'b0}});
      assign d_in = rng ? (data_addr >= car_r[i] && data_addr <= hi)
                        : (((data_addr ^ car_r[i]) & amask) == {AW{1'b0}});

      assign f_m = on & fetch_valid & ctl_r[i][`CTBL_CH_PC] & f_in;

      assign d_kind = data_write ? ctl_r[i][`CTBL_CH_WR] : ctl_r[i][`CTBL_CH_RD];
      assign d_cond = data_valid & d_kind & d_in;
      assign d_m    = on & d_cond;

      if (i % 2 == 0) begin : g_even
        wire mate;
        // second half must match the access direction too
        assign mate = data_write ? ctl_r[i + 1][`CTBL_CH_WR] : ctl_r[i + 1][`CTBL_CH_RD];
        // both halves seen in one instruction
        assign dhit[i] = cplx
          ? on & (d_cond | seen_r[i]) &
            ((data_valid & mate &
              (((data_addr ^ car_r[i + 1]) & {AW{1'b1}}) == {AW{1'b0}})) |
             seen_r[i + 1]) & (d_cond | data_valid)
          : d_m;
      end else begin : g_odd
        assign dhit[i] = d_m;
      end
      assign fhit[i] = f_m & ~cplx;
    end
  endgenerate

  assign any_fhit = |fhit;
  assign any_dhit = |dhit;

  // per-instruction memory of complex halves
  always @(posedge sys_clk) begin
    if (rst) begin
      seen_r <= {NCH{1'b0}};
    end else if (inst_begin) begin
      seen_r <= {NCH{1'b0}};
    end else if (data_valid) begin
      for (ks = 0; ks < NCH; ks = ks + 2) begin
        if (ctl_r[ks][`CTBL_CH_CPLX] && gen_r) begin
          if ((((data_addr ^ car_r[ks]) &
              ({AW{1'b1}} << ctl_r[ks][`CTBL_CH_MSK_HI:`CTBL_CH_MSK_LO])) == {AW{1'b0}}) &&
              (data_write ? ctl_r[ks][`CTBL_CH_WR] : ctl_r[ks][`CTBL_CH_RD])) begin
            seen_r[ks] <= 1'b1;
          end
          if (data_addr == car_r[ks + 1] &&
              (data_write ? ctl_r[ks + 1][`CTBL_CH_WR] : ctl_r[ks + 1][`CTBL_CH_RD])) begin
            seen_r[ks + 1] <= 1'b1;
          end
        end
      end
    end
  end

  // tag travels with the fetched word
  always @(posedge sys_clk) begin
    if (rst) begin
      fetch_tag_r <= 1'b0;
    end else begin
      fetch_tag_r <= any_fhit;
    end
  end

  // data hits stay pending until the instruction completes
  assign take_dbg = exec_tagged | dbg_pend_r;

  // sticky channel hits; a hit in the clearing cycle survives
  always @(posedge sys_clk) begin
    if (rst) begin
      hit_r <= {NCH{1'b0}};
    end else begin
      hit_r <= (hit_r & ~((wr_go && rd_ok && avs_address == `CTBL_DSR_OFF) ?
                          avs_writedata[NCH-1:0] : {NCH{1'b0}})) |
               fhit | dhit;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      dbg_pend_r <= 1'b0;
    end else if (any_dhit) begin
      dbg_pend_r <= 1'b1;
    end else if (inst_begin) begin
      dbg_pend_r <= 1'b0;
    end
  end

  // fixed check order at instruction start
  always @(posedge sys_clk) begin
    if (rst) begin
      exc_valid_r <= 1'b0;
      exc_code_r  <= `CTBL_EXC_RUN;
    end else begin
      exc_valid_r <= inst_begin;
      if (inst_begin) begin
        if (take_dbg) begin
          exc_code_r <= `CTBL_EXC_BRK;
        end else if (bad_addr_pending) begin
          exc_code_r <= `CTBL_EXC_ADR;
        end else if (irq_pending) begin
          exc_code_r <= `CTBL_EXC_IRQ;
        end else if (p_eff) begin
          exc_code_r <= `CTBL_EXC_STEP;
        end else begin
          exc_code_r <= `CTBL_EXC_RUN;
        end
      end
    end
  end

  // status word trace bits
  always @(posedge sys_clk) begin
    if (rst) begin
      te_r <= 1'b0;
      tp_r <= 1'b0;
    end else if (wr_go && avs_address == `CTBL_STAT_OFF) begin
      // software load wins over hardware copy
      te_r <= avs_writedata[`CTBL_STAT_TE];
      tp_r <= avs_writedata[`CTBL_STAT_TP];
    end else if (exc_enter) begin
      // handler runs untraced; bits come back on return
      te_r <= 1'b0;
      tp_r <= 1'b0;
    end else if (exc_return) begin
      te_r <= ret_trace_enable;
      tp_r <= ret_trace_pending;
    end else if (inst_begin && !take_dbg && !bad_addr_pending && !irq_pending) begin
      if (p_eff) begin
        tp_r <= 1'b0;
      end else begin
        tp_r <= t_eff;
      end
    end
  end

  // breakpoint instruction outcome
  always @(posedge sys_clk) begin
    if (rst) begin
      bpt_trap_r     <= 1'b0;
      dbg_mode_req_r <= 1'b0;
    end else begin
      bpt_trap_r     <= inst_bpt & ~hw_dbg_present;
      dbg_mode_req_r <= inst_bpt & hw_dbg_present;
    end
  end

endmodule // ctbl_core

// ### test/ctbl_core_assertions.sv
// port-level checks of the trace and breakpoint block
module ctbl_chk (
  input wire       sys_clk,
  input wire       rst,
  input wire       avs_read,
  input wire       avs_write,
  input wire       avs_waitrequest,
  input wire       hw_dbg_present,
  input wire       inst_begin,
  input wire       exec_tagged,
  input wire       bad_addr_pending,
  input wire       irq_pending,
  input wire       inst_bpt,
  input wire       exc_enter,
  input wire       exc_return,
  input wire       ret_trace_pending,
  input wire       exc_valid_r,
  input wire [2:0] exc_code_r,
  input wire       bpt_trap_r,
  input wire       dbg_mode_req_r,
  input wire       trace_enable_bit,
  input wire       trace_pending_bit
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // nothing but a pending data hit outranks the trace check
  wire quiet = !exec_tagged && !bad_addr_pending && !irq_pending && !hw_dbg_present;

  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  a_exc_timing: assert property (exc_valid_r == $past(inst_begin))
    else $error("check result not one cycle after begin");
  a_dbg_first: assert property (inst_begin && exec_tagged |=> exc_code_r == 3'h1)
    else $error("tagged instruction not stopped");
  a_trc_take: assert property (inst_begin && quiet && trace_pending_bit |=> exc_code_r == 3'h4 && !trace_pending_bit)
    else $error("pending trace not taken");
  a_pend_copy: assert property (inst_begin && quiet && !trace_pending_bit && !avs_write
    |=> trace_pending_bit == $past(trace_enable_bit))
    else $error("enable not copied to pending");
  a_hw_nostep: assert property (inst_begin && hw_dbg_present && !trace_pending_bit && !avs_write |=> !trace_pending_bit)
    else $error("stepping with debugger attached");
  a_bpt_trap: assert property (inst_bpt && !hw_dbg_present |=> bpt_trap_r && !dbg_mode_req_r)
    else $error("breakpoint trap missing");
  a_bpt_dbg: assert property (inst_bpt && hw_dbg_present |=> dbg_mode_req_r && !bpt_trap_r)
    else $error("debug mode request missing");
  a_enter_clr: assert property (exc_enter && !avs_write |=> !trace_enable_bit && !trace_pending_bit)
    else $error("trace bits kept on entry");
  a_ret_load: assert property (exc_return && !exc_enter && !avs_write
    |=> trace_pending_bit == $past(ret_trace_pending))
    else $error("pending not restored");

  c_trc: cover property (exc_valid_r && exc_code_r == 3'h4);
  c_bpt: cover property (bpt_trap_r);
  c_dbg: cover property (dbg_mode_req_r);
endmodule // ctbl_chk

bind ctbl_core ctbl_chk i_ctbl_chk (
  .sys_clk(sys_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .hw_dbg_present(hw_dbg_present), .inst_begin(inst_begin),
  .exec_tagged(exec_tagged), .bad_addr_pending(bad_addr_pending), .irq_pending(irq_pending),
  .inst_bpt(inst_bpt),
  .exc_enter(exc_enter), .exc_return(exc_return), .ret_trace_pending(ret_trace_pending),
  .exc_valid_r(exc_valid_r), .exc_code_r(exc_code_r), .bpt_trap_r(bpt_trap_r), .dbg_mode_req_r(dbg_mode_req_r),
  .trace_enable_bit(trace_enable_bit), .trace_pending_bit(trace_pending_bit)
);

// ### test/ctbl_mon.sv
// bus master standing in for the monitor's privileged register moves
module ctbl_mon (
  input  wire         sys_clk,
  output logic [6:0]  avs_address,
  output logic        avs_read,
  output logic        avs_write,
  output logic [31:0] avs_writedata,
  input  wire  [31:0] avs_readdata,
  input  wire         avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    avs_address = 7'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [6:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // answer and read data are taken at the same rising edge
    @(posedge sys_clk);
    while (avs_waitrequest) @(posedge sys_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // released data must not look like a held value
    avs_writedata <= ~d;
  endtask
endmodule // ctbl_mon

// ### test/core_trace_breakpoint_logic_tb_top.sv
// self-checking bench of the trace and breakpoint block
module core_trace_breakpoint_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst, hw, fv, dv, dw, ib, tg, bad, irq, rte, rtp;
  logic [2:0]  pv;
  logic [23:0] fa, da;
  logic [31:0] q;
  wire  [6:0]  ad;
  wire  [31:0] wd, rq;
  wire  [2:0]  code;
  wire         rd, wr, wq, tag, ev, bt, dm, te, tp;
  int          fail_count, n_compared;

  ctbl_mon i_ctbl_mon (.sys_clk(sys_clk), .avs_address(ad), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rq), .avs_waitrequest(wq));
  ctbl_core i_ctbl_core (.sys_clk(sys_clk), .rst(rst), .avs_address(ad), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rq), .avs_waitrequest(wq), .hw_dbg_present(hw), .fetch_valid(fv),
    .fetch_addr(fa), .fetch_tag_r(tag), .data_valid(dv), .data_write(dw), .data_addr(da), .inst_begin(ib),
    .exec_tagged(tg), .bad_addr_pending(bad), .irq_pending(irq), .inst_bpt(pv[2]), .exc_enter(pv[1]),
    .exc_return(pv[0]), .ret_trace_enable(rte), .ret_trace_pending(rtp), .exc_valid_r(ev),
    .exc_code_r(code), .bpt_trap_r(bt), .dbg_mode_req_r(dm), .trace_enable_bit(te), .trace_pending_bit(tp));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [6:0] a, input logic [31:0] d);
    i_ctbl_mon.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [31:0] e);
    i_ctbl_mon.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // f = {tagged, invalid address, interrupt}
  task automatic ibeg(input logic [2:0] f, input logic [2:0] e);
    {tg, bad, irq} <= f;
    ib <= 1'b1;
    @(posedge sys_clk);
    ib <= 1'b0;
    @(negedge sys_clk);
    chk({ev, code}, {1'b1, e});
    @(posedge sys_clk);
  endtask
  task automatic fe(input logic [23:0] a, input logic e);
    fv <= 1'b1;
    fa <= a;
    @(posedge sys_clk);
    fv <= 1'b0;
    @(negedge sys_clk);
    chk(tag, e);
    @(posedge sys_clk);
  endtask
  task automatic dac(input logic [23:0] a, input logic w);
    dv <= 1'b1;
    da <= a;
    dw <= w;
    @(posedge sys_clk);
    dv <= 1'b0;
    @(posedge sys_clk);
  endtask
  // one-cycle pulse of {breakpoint, entry, return}
  task automatic pls(input logic [2:0] v);
    @(posedge sys_clk);
    pv <= v;
    @(posedge sys_clk);
    pv <= 3'h0;
    @(negedge sys_clk);
  endtask

  task automatic t_regs();
    rdc(7'h00, 32'h0);
    wrr(7'h08, 32'h1);
    rdc(7'h08, 32'h1);
    wrr(7'h04, 32'hFFABCDEF);
    rdc(7'h04, 32'h00ABCDEF);
    rdc(7'h7C, 32'h0);
  endtask
  task automatic t_trace();
    logic [2:0] fs[3] = '{3'h4, 3'h2, 3'h1};
    logic [2:0] es[3] = '{3'h1, 3'h2, 3'h3};
    wrr(7'h00, 32'h1);
    ibeg(3'h0, 3'h0);
    chk(tp, 1'b1);
    ibeg(3'h0, 3'h4);
    chk(tp, 1'b0);
    ibeg(3'h0, 3'h0);
    for (int i = 0; i < 3; i++) ibeg(fs[i], es[i]);
    ibeg(3'h0, 3'h4);
    wrr(7'h00, 32'h3);
    rte <= 1'b1;
    rtp <= 1'b1;
    pls(3'h2);
    chk({te, tp}, 2'h0);
    pls(3'h1);
    chk({te, tp}, 2'h3);
    @(posedge sys_clk);
    ibeg(3'h0, 3'h4);
    wrr(7'h00, 32'h0);
  endtask
  task automatic t_bpt();
    pls(3'h4);
    chk({bt, dm}, 2'h2);
    @(posedge sys_clk);
    hw <= 1'b1;
    pls(3'h4);
    chk({bt, dm}, 2'h1);
    @(posedge sys_clk);
    wrr(7'h08, 32'h0);
    rdc(7'h08, 32'h0);
    wrr(7'h00, 32'h1);
    ibeg(3'h0, 3'h0);
    chk(tp, 1'b0);
    wrr(7'h00, 32'h0);
    hw <= 1'b0;
    rdc(7'h08, 32'h1);
  endtask
  task automatic t_fetch();
    for (int n = 0; n < 8; n++) begin
      wrr(7'h40 + 7'(4 * n), 32'h800 + 32'(2 * n));
      wrr(7'h20 + 7'(4 * n), 32'h1);
      fe(24'h800 + 24'(2 * n), 1'b1);
      fe(24'h804 + 24'(2 * n), 1'b0);
      wrr(7'h20 + 7'(4 * n), 32'h0);
    end
    wrr(7'h40, 32'h100);
    wrr(7'h20, 32'h7);
    fe(24'h106, 1'b1);
    fe(24'h108, 1'b0);
    wrr(7'h44, 32'h10A);
    wrr(7'h20, 32'h9);
    fe(24'h10A, 1'b1);
    fe(24'h10C, 1'b0);
    wrr(7'h08, 32'h0);
    fe(24'h104, 1'b0);
    wrr(7'h08, 32'h1);
    wrr(7'h20, 32'h0);
  endtask
  task automatic t_data();
    wrr(7'h50, 32'h300);
    wrr(7'h30, 32'h10);
    dac(24'h300, 1'b0);
    ibeg(3'h0, 3'h0);
    dac(24'h300, 1'b1);
    ibeg(3'h0, 3'h1);
    wrr(7'h30, 32'h26);
    dac(24'h305, 1'b0);
    ibeg(3'h0, 3'h1);
    dac(24'h308, 1'b0);
    ibeg(3'h0, 3'h0);
    wrr(7'h54, 32'h310);
    wrr(7'h30, 32'h18);
    dac(24'h310, 1'b1);
    ibeg(3'h0, 3'h1);
    dac(24'h311, 1'b1);
    ibeg(3'h0, 3'h0);
    // complex pair: write to the first address, then read of the second
    wrr(7'h58, 32'h400);
    wrr(7'h5C, 32'h402);
    wrr(7'h3C, 32'h20);
    wrr(7'h38, 32'h50);
    dac(24'h400, 1'b1);
    dac(24'h402, 1'b1);
    ibeg(3'h0, 3'h0);
    dac(24'h400, 1'b1);
    dac(24'h402, 1'b0);
    ibeg(3'h0, 3'h1);
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // generous bound: the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    {hw, fv, dv, dw, ib, tg, bad, irq, rte, rtp} = '0;
    pv = 3'h0;
    fa = 24'h0;
    da = 24'h0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_trace();
    t_bpt();
    t_fetch();
    t_data();
    end_of_test();
  end
endmodule // core_trace_breakpoint_logic_tb_top
